// >>> rtl/panel_pkg.sv
// Constants and types for the panel switch and indicator block
package panel_pkg;

   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int CLK_KHZ      = 50000;
   localparam int DEBOUNCE_MS  = 10;
   localparam int BLINK_ON_MS  = 200;
   localparam int BLINK_OFF_MS = 300;
   localparam int BLINK_GAP_MS = 1500;
   localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
   localparam int BLINK_ON_CYC = BLINK_ON_MS * CLK_KHZ;
   localparam int BLINK_OFF_CYC = BLINK_OFF_MS * CLK_KHZ;
   localparam int BLINK_GAP_CYC = BLINK_GAP_MS * CLK_KHZ;

   // ----------------------------------------
   // Switches
   // ----------------------------------------
   typedef enum logic [1:0] {
      SLIDE_MID = 2'h0,
      SLIDE_TOP = 2'h1,
      SLIDE_BOT = 2'h2
   } slide_t;

   typedef struct packed {
      slide_t     protect;
      slide_t     port_mode;
      logic [3:0] tens;
      logic [3:0] ones;
   } switches_t;

   // Protection on until the switches have settled
   localparam switches_t SW_RST = '{SLIDE_TOP, SLIDE_MID, 4'h0, 4'h0};
   localparam logic [3:0] DIGIT_MAX = 4'h9;
   localparam logic [7:0] ADDR_MAX  = 8'h40;
   localparam logic [7:0] TENS_WT   = 8'h0a;

   // ----------------------------------------
   // Serial link settings
   // ----------------------------------------
   typedef enum logic [3:0] {
      BAUD_50, BAUD_75, BAUD_110, BAUD_134P5, BAUD_150, BAUD_300, BAUD_600,
      BAUD_1200, BAUD_1800, BAUD_2000, BAUD_2400, BAUD_3600, BAUD_4800,
      BAUD_7200, BAUD_9600, BAUD_19200
   } baud_t;

   typedef struct packed {
      baud_t      baud;
      logic       par_en;
      logic       par_odd;
      logic       data8;
      logic       stop2;
      logic [7:0] addr;
   } link_cfg_t;

   localparam baud_t ASCII_BAUD  = BAUD_2400;
   localparam logic  ASCII_DATA8 = 1'b0;
   localparam baud_t RTU_BAUD    = BAUD_9600;
   localparam logic  RTU_DATA8   = 1'b1;

   // ----------------------------------------
   // Run LED blink coding
   // ----------------------------------------
   localparam logic [3:0] BLINKS_NONE   = 4'h0;
   localparam logic [3:0] BLINKS_STEADY = 4'hf;

   typedef enum logic [1:0] {
      BL_IDLE = 2'b00,
      BL_ON   = 2'b01,
      BL_OFF  = 2'b11,
      BL_GAP  = 2'b10
   } blink_st_t;

endpackage

// >>> rtl/panel_indicator.sv
// Panel switch decoding and LED indication for the controller front and rear
`timescale 1ns/1ps

module panel_indicator #(
   parameter int DEBOUNCE_CYC = panel_pkg::DEBOUNCE_CYC,
   parameter int ON_CYC       = panel_pkg::BLINK_ON_CYC,
   parameter int OFF_CYC      = panel_pkg::BLINK_OFF_CYC,
   parameter int GAP_CYC      = panel_pkg::BLINK_GAP_CYC
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // Front and rear panel switches
   input  wire panel_pkg::slide_t    protect_sw,
   input  wire panel_pkg::slide_t    port_mode_sw,
   input  wire logic [3:0]           tens_address_selector,
   input  wire logic [3:0]           ones_address_selector,
   // Software link settings and controller status
   input  wire panel_pkg::link_cfg_t soft_link,
   input  wire logic                 ctrl_running,
   input  wire logic                 err_active,
   input  wire logic [15:0]          err_code,
   input  wire logic                 net_activity,
   // Decoded settings
   output logic                      write_protect,
   output panel_pkg::link_cfg_t      link_cfg,
   output logic                      bridge_mode,
   output logic [7:0]                node_addr,
   output logic                      addr_invalid,
   output logic                      switches_valid,
   // Indicators
   output logic                      wp_led,
   output logic                      net_led,
   output logic                      run_led
);

   localparam int DW = $clog2(DEBOUNCE_CYC + 1);
   localparam int TW = $clog2(GAP_CYC + 1);

   // Gap must stay visibly longer than the dark time inside a group
   generate
      if (DEBOUNCE_CYC < 1 || ON_CYC < 1 || OFF_CYC < 1 ||
          GAP_CYC <= OFF_CYC || GAP_CYC < ON_CYC)
      begin : g_bad
         $error("panel_indicator: bad timing parameters");
      end
   endgenerate

   // ----------------------------------------
   // Error code to blink count
   // ----------------------------------------
   function automatic logic [3:0] blink_count(input logic [15:0] c);
      logic [3:0] n;
      n = panel_pkg::BLINKS_NONE;
      if (c == 16'h0000)
         n = panel_pkg::BLINKS_STEADY;
      else if (c == 16'h080b || c == 16'h080c || c == 16'h082e)
         n = 4'h2;
      else if (c == 16'h0769 || (c >= 16'h072a && c <= 16'h0730))
         n = 4'h3;
      else if (c >= 16'h0604 && c <= 16'h0631)
         n = 4'h4;
      else if (c == 16'h0503 || c == 16'h052d)
         n = 4'h5;
      else if (c == 16'h0402)
         n = 4'h6;
      else if (c == 16'h0300 || c == 16'h0301)
         n = 4'h7;
      else if (c >= 16'h8001 && c <= 16'h8003)
         n = 4'h8;
      return n;
   endfunction

   // ----------------------------------------
   // Switch debounce
   // ----------------------------------------
   panel_pkg::switches_t raw_sw;
   panel_pkg::switches_t sample_q;
   panel_pkg::switches_t stable_q;
   logic [DW-1:0]        db_cnt_q;
   logic                 valid_q;
   wire                  db_moved;
   wire                  db_done;

   assign raw_sw   = '{protect_sw, port_mode_sw, tens_address_selector, ones_address_selector};
   assign db_moved = (raw_sw != sample_q);
   assign db_done  = !db_moved && (db_cnt_q == DW'(DEBOUNCE_CYC - 1));

   // Any movement restarts the count, so a bouncing contact never reaches the decode
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sample_q <= panel_pkg::SW_RST;
         stable_q <= panel_pkg::SW_RST;
         db_cnt_q <= '0;
         valid_q  <= 1'b0;
      end
      else
      begin
         sample_q <= raw_sw;
         db_cnt_q <= (db_moved || db_done) ? '0 : db_cnt_q + DW'(1);
         if (db_done)
         begin
            stable_q <= sample_q;
            valid_q  <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Settings decode
   // ----------------------------------------
   panel_pkg::link_cfg_t link_fix;
   panel_pkg::link_cfg_t link_d;
   wire [7:0] node_sum;
   wire       digit_bad;
   wire       addr_bad;
   wire       fixed_mode;
   wire       ascii_mode;
   wire       wp_d;

   assign node_sum   = {4'h0, stable_q.tens} * panel_pkg::TENS_WT
                       + {4'h0, stable_q.ones};
   assign digit_bad  = (stable_q.tens > panel_pkg::DIGIT_MAX) ||
                       (stable_q.ones > panel_pkg::DIGIT_MAX);
   assign addr_bad   = digit_bad || (node_sum == 8'h00) ||
                       (node_sum > panel_pkg::ADDR_MAX);
   assign wp_d       = (stable_q.protect == panel_pkg::SLIDE_TOP);
   assign ascii_mode = (stable_q.port_mode == panel_pkg::SLIDE_TOP);
   // An unused switch code falls to the RTU setting rather than to software
   assign fixed_mode = (stable_q.port_mode != panel_pkg::SLIDE_BOT);
   assign link_fix   = '{baud:    ascii_mode ? panel_pkg::ASCII_BAUD
                                             : panel_pkg::RTU_BAUD,
                         par_en:  1'b1,
                         par_odd: 1'b0,
                         data8:   ascii_mode ? panel_pkg::ASCII_DATA8
                                             : panel_pkg::RTU_DATA8,
                         stop2:   1'b0,
                         addr:    node_sum};
   assign link_d     = fixed_mode ? link_fix : soft_link;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         write_protect <= 1'b1;
         wp_led        <= 1'b1;
         link_cfg      <= '0;
         bridge_mode   <= 1'b0;
         node_addr     <= '0;
         addr_invalid  <= 1'b1;
         net_led       <= 1'b1;
      end
      else
      begin
         write_protect <= wp_d;
         wp_led        <= wp_d;
         link_cfg      <= link_d;
         bridge_mode   <= fixed_mode;
         node_addr     <= node_sum;
         addr_invalid  <= addr_bad;
         net_led       <= addr_bad || net_activity;
      end
   end

   assign switches_valid = valid_q;

   // ----------------------------------------
   // Run LED blink sequencer
   // ----------------------------------------
   panel_pkg::blink_st_t st_q;
   panel_pkg::blink_st_t st_d;
   logic [TW-1:0] tmr_q;
   logic [TW-1:0] tmr_d;
   logic [3:0]    pulses_q;
   logic [3:0]    pulses_d;
   logic [3:0]    total_q;
   logic [3:0]    total_d;
   wire  [3:0]    blink_total;
   wire           blink_go;
   wire           steady_err;

   assign blink_total = blink_count(err_code);
   assign steady_err  = err_active && (blink_total == panel_pkg::BLINKS_STEADY);
   assign blink_go    = err_active && !ctrl_running && !steady_err &&
                        (blink_total != panel_pkg::BLINKS_NONE);

   always_comb
   begin
      st_d     = st_q;
      tmr_d    = tmr_q + TW'(1);
      pulses_d = pulses_q;
      total_d  = total_q;
      case (st_q)
         panel_pkg::BL_IDLE:
         begin
            tmr_d = '0;
            if (blink_go)
            begin
               st_d     = panel_pkg::BL_ON;
               total_d  = blink_total;
               pulses_d = 4'h1;
            end
         end
         panel_pkg::BL_ON:
            if (tmr_q == TW'(ON_CYC - 1))
            begin
               tmr_d = '0;
               st_d  = (pulses_q == total_q) ? panel_pkg::BL_GAP : panel_pkg::BL_OFF;
            end
         panel_pkg::BL_OFF:
            if (tmr_q == TW'(OFF_CYC - 1))
            begin
               tmr_d    = '0;
               st_d     = panel_pkg::BL_ON;
               pulses_d = pulses_q + 4'h1;
            end
         panel_pkg::BL_GAP:
            if (tmr_q == TW'(GAP_CYC - 1))
            begin
               tmr_d = '0;
               st_d  = panel_pkg::BL_IDLE;
            end
         default:
         begin
            tmr_d = '0;
            st_d  = panel_pkg::BL_IDLE;
         end
      endcase
   end

   // A group already started finishes even if the error clears, so no half count shows
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_q     <= panel_pkg::BL_IDLE;
         tmr_q    <= '0;
         pulses_q <= '0;
         total_q  <= '0;
         run_led  <= 1'b0;
      end
      else
      begin
         st_q     <= st_d;
         tmr_q    <= tmr_d;
         pulses_q <= pulses_d;
         total_q  <= total_d;
         run_led  <= ctrl_running || steady_err || (st_q == panel_pkg::BL_ON);
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_group_start;
      st_q == panel_pkg::BL_IDLE && blink_go;
   endsequence

   sequence s_last_on;
      st_q == panel_pkg::BL_ON && tmr_q == TW'(ON_CYC - 1) && pulses_q == total_q;
   endsequence

   a_protect_switch: assert property (
      stable_q.protect == panel_pkg::SLIDE_TOP |=> write_protect)
      else $error("protection not enabled with switch at top");

   a_wp_led_on: assert property (
      $past(stable_q.protect) != panel_pkg::SLIDE_TOP || wp_led)
      else $error("write-protect LED dark while protected");

   a_ascii_fixed: assert property (
      stable_q.port_mode == panel_pkg::SLIDE_TOP |=>
      link_cfg.baud == panel_pkg::BAUD_2400 && !link_cfg.data8 &&
      link_cfg.par_en && !link_cfg.par_odd && !link_cfg.stop2)
      else $error("ASCII link settings wrong");

   a_rtu_fixed: assert property (
      stable_q.port_mode == panel_pkg::SLIDE_MID |=>
      link_cfg.baud == panel_pkg::BAUD_9600 && link_cfg.data8 &&
      link_cfg.par_en && !link_cfg.par_odd && !link_cfg.stop2)
      else $error("RTU link settings wrong");

   a_soft_link: assert property (
      stable_q.port_mode == panel_pkg::SLIDE_BOT |=>
      link_cfg == $past(soft_link) && !bridge_mode)
      else $error("software link settings not applied");

   a_fixed_bridge: assert property (
      stable_q.port_mode != panel_pkg::SLIDE_BOT |=>
      bridge_mode && link_cfg.addr == node_addr)
      else $error("fixed mode without bridge or switch address");

   a_addr_sum: assert property (
      !digit_bad |=> node_addr == 8'(10 * $past(stable_q.tens) + $past(stable_q.ones)))
      else $error("node address sum wrong");

   a_addr_valid: assert property (
      !addr_invalid |-> node_addr >= 8'h01 && node_addr <= panel_pkg::ADDR_MAX ##0 1 ##1
      addr_invalid || !$past(net_activity) || net_led)
      else $error("address range or network LED wrong");

   a_invalid_led: assert property (
      addr_invalid |-> net_led)
      else $error("network LED not steady on bad address");

   a_run_steady: assert property (
      ctrl_running [*2] |=> run_led)
      else $error("run LED not steady while running");

   a_group_start: assert property (
      s_group_start |=> st_q == panel_pkg::BL_ON && pulses_q == 4'h1 &&
      total_q == $past(blink_total) && total_q >= 4'h2 && total_q <= 4'h8)
      else $error("blink group started wrong");

   a_group_gap: assert property (
      s_last_on |=> st_q == panel_pkg::BL_GAP && tmr_q == '0 ##1
      (!run_led || $past(ctrl_running) || $past(steady_err)))
      else $error("blink group not followed by gap");

   a_debounce_hold: assert property (
      $changed(stable_q) |-> $past(db_cnt_q) == DW'(DEBOUNCE_CYC - 1) &&
      !$past(db_moved) && valid_q)
      else $error("switch settings applied before stable");

endmodule

// >>> verification/panel_operator.sv
// Operator model: watches the run LED and counts the blinks of each group
`timescale 1ns/1ps
module panel_operator #(
   parameter int GAP_MIN = 5
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Indicator watched by the operator
   input  wire logic run_led,
   // Result of the last complete group
   output int        group_blinks,
   output logic      group_done
);
   int   cnt_q;
   int   dark_q;
   logic led_q;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_q        <= 0;
         dark_q       <= 0;
         led_q        <= 1'b0;
         group_blinks <= 0;
         group_done   <= 1'b0;
      end
      else
      begin
         led_q      <= run_led;
         group_done <= 1'b0;
         dark_q     <= run_led ? 0 : dark_q + 1;
         if (run_led && !led_q)
            cnt_q <= cnt_q + 1;
         // Only a dark spell longer than the off time ends a group
         if (!run_led && dark_q == GAP_MIN && cnt_q > 0)
         begin
            group_blinks <= cnt_q;
            group_done   <= 1'b1;
            cnt_q        <= 0;
         end
      end
   end
endmodule

// >>> verification/panel_indicator_tb.sv
// Self-checking bench for the panel switch and indicator block
`timescale 1ns/1ps
module panel_indicator_tb;
   // Short counts keep the run brief; gap well above off time
   localparam int DEB = 8;
   localparam int ON  = 3;
   localparam int OFF = 3;
   localparam int GAP = 10;

   logic                 clk;
   logic                 rst;
   panel_pkg::slide_t    protect_sw;
   panel_pkg::slide_t    port_mode_sw;
   logic [3:0]           tens;
   logic [3:0]           ones;
   panel_pkg::link_cfg_t soft_link;
   logic                 ctrl_running;
   logic                 err_active;
   logic [15:0]          err_code;
   logic                 net_activity;
   logic                 write_protect;
   panel_pkg::link_cfg_t link_cfg;
   logic                 bridge_mode;
   logic [7:0]           node_addr;
   logic                 addr_invalid;
   logic                 switches_valid;
   logic                 wp_led;
   logic                 net_led;
   logic                 run_led;
   int                   group_blinks;
   logic                 group_done;
   int                   failures;
   int                   num_checks;
   int                   i;
   logic                 stuck;
   logic [15:0]          sw_q[$];
   logic [15:0]          codes[$];

   panel_indicator #(.DEBOUNCE_CYC(DEB), .ON_CYC(ON), .OFF_CYC(OFF), .GAP_CYC(GAP)) dut (
      .clk(clk), .rst(rst), .protect_sw(protect_sw), .port_mode_sw(port_mode_sw),
      .tens_address_selector(tens), .ones_address_selector(ones), .soft_link(soft_link),
      .ctrl_running(ctrl_running), .err_active(err_active), .err_code(err_code),
      .net_activity(net_activity), .write_protect(write_protect), .link_cfg(link_cfg),
      .bridge_mode(bridge_mode), .node_addr(node_addr), .addr_invalid(addr_invalid),
      .switches_valid(switches_valid), .wp_led(wp_led), .net_led(net_led), .run_led(run_led));

   panel_operator #(.GAP_MIN(OFF + 2)) op (
      .clk(clk), .rst(rst), .run_led(run_led), .group_blinks(group_blinks),
      .group_done(group_done));

   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("checks %0d, failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ----------------------------------------
   // Reference model
   // ----------------------------------------
   function automatic int blinks(input logic [15:0] c);
      if (c == 16'h080b || c == 16'h080c || c == 16'h082e) return 2;
      if (c == 16'h0769 || (c >= 16'h072a && c <= 16'h0730)) return 3;
      if (c >= 16'h0604 && c <= 16'h0631) return 4;
      if (c == 16'h0503 || c == 16'h052d) return 5;
      if (c == 16'h0402) return 6;
      if (c == 16'h0300 || c == 16'h0301) return 7;
      if (c >= 16'h8001 && c <= 16'h8003) return 8;
      return 0;
   endfunction

   function automatic panel_pkg::link_cfg_t exp_link(input logic [1:0] m, input int a);
      panel_pkg::link_cfg_t e;
      e = soft_link;
      if (m != 2'h2)
      begin
         e.baud    = (m == 2'h1) ? panel_pkg::ASCII_BAUD : panel_pkg::RTU_BAUD;
         e.par_en  = 1'b1;
         e.par_odd = 1'b0;
         e.data8   = (m == 2'h1) ? panel_pkg::ASCII_DATA8 : panel_pkg::RTU_DATA8;
         e.stop2   = 1'b0;
         e.addr    = a[7:0];
      end
      return e;
   endfunction

   // Switch word: protect in [13:12], port mode in [9:8], tens, ones
   task automatic apply(input logic [15:0] s);
      int   a;
      logic inv;
      a   = int'(s[7:4]) * 10 + int'(s[3:0]);
      inv = s[7:4] > 4'h9 || s[3:0] > 4'h9 || a == 0 || a > 64;
      protect_sw   = panel_pkg::slide_t'(s[13:12]);
      port_mode_sw = panel_pkg::slide_t'(s[9:8]);
      tens         = s[7:4];
      ones         = s[3:0];
      repeat (DEB + 4) @(negedge clk);
      check("write_protect", write_protect, s[13:12] == 2'h1);
      check("wp_led", wp_led, s[13:12] == 2'h1);
      check("bridge_mode", bridge_mode, s[9:8] != 2'h2);
      check("node_addr", node_addr, a[7:0]);
      check("addr_invalid", addr_invalid, inv);
      check("net_led", net_led, inv);
      check("switches_valid", switches_valid, 1'b1);
      check("link_cfg", link_cfg, exp_link(s[9:8], a));
      soft_link = panel_pkg::link_cfg_t'(16'($urandom));
      repeat (2) @(negedge clk);
      check("link_cfg", link_cfg, exp_link(s[9:8], a));
   endtask

   task automatic blink(input logic [15:0] c);
      int n;
      err_active = 1'b0;
      repeat (80) @(negedge clk);
      err_code   = c;
      err_active = 1'b1;
      for (n = 0; n < 300 && group_done !== 1'b1; n++)
         @(negedge clk);
      if (n == 300)
      begin
         failures++;
         stuck = 1'b1;
      end
      else
         check("blinks", group_blinks, blinks(c));
      @(negedge clk);
   endtask

   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial
   begin
      rst          = 1'b1;
      protect_sw   = panel_pkg::SLIDE_MID;
      port_mode_sw = panel_pkg::SLIDE_MID;
      tens         = 4'h0;
      ones         = 4'h0;
      soft_link    = '0;
      ctrl_running = 1'b0;
      err_active   = 1'b0;
      err_code     = 16'h0000;
      net_activity = 1'b0;
      failures     = 0;
      num_checks   = 0;
      stuck        = 1'b0;
      i            = $urandom(96509);
      repeat (2) @(negedge clk);
      check("write_protect", write_protect, 1'b1);
      check("switches_valid", switches_valid, 1'b0);
      rst = 1'b0;
      sw_q = '{16'h1164, 16'h0065, 16'h2200, 16'h3301, 16'h1299, 16'h01a3, 16'h2264};
      for (i = 0; i < 10; i++)
         sw_q.push_back({2'h0, 2'($urandom_range(0, 3)), 2'h0, 2'($urandom_range(0, 3)),
                         4'($urandom_range(0, 10)), 4'($urandom_range(0, 10))});
      foreach (sw_q[j])
         apply(sw_q[j]);
      // A bounce shorter than the window must leave protection on
      apply(16'h1112);
      protect_sw = panel_pkg::SLIDE_MID;
      for (i = 0; i < 2 * DEB + 2; i++)
      begin
         if (i == DEB - 2)
            protect_sw = panel_pkg::SLIDE_TOP;
         @(negedge clk);
         check("write_protect", write_protect, 1'b1);
      end
      net_activity = 1'b1;
      repeat (2) @(negedge clk);
      check("net_led", net_led, 1'b1);
      net_activity = 1'b0;
      ctrl_running = 1'b1;
      err_active   = 1'b1;
      err_code     = 16'h080b;
      repeat (3) @(negedge clk);
      for (i = 0; i < 40; i++)
      begin
         check("run_led", run_led, 1'b1);
         @(negedge clk);
      end
      ctrl_running = 1'b0;
      err_code     = 16'h0123;
      repeat (3) @(negedge clk);
      for (i = 0; i < 60; i++)
      begin
         check("run_led", run_led, 1'b0);
         @(negedge clk);
      end
      // Code zero is reported as a steadily lit run LED
      err_code     = 16'h0000;
      repeat (3) @(negedge clk);
      for (i = 0; i < 20; i++)
      begin
         check("run_led", run_led, 1'b1);
         @(negedge clk);
      end
      codes = '{16'h080b, 16'h080c, 16'h082e, 16'h0769, 16'h072a, 16'h072c, 16'h0730,
                16'h0604, 16'h0617, 16'h0631, 16'h0503, 16'h052d, 16'h0402, 16'h0300,
                16'h0301, 16'h8001, 16'h8002, 16'h8003};
      foreach (codes[j])
         if (!stuck)
            blink(codes[j]);
      test_done();
   end
endmodule
